/* File: bench/ccw_wake_net.sv */
// Contact network on the wake pins: switch to ground, pull-up when open
`timescale 1ns/1ps
`default_nettype none
module ccw_wake_net (
  input  wire logic [2:0] closed,   // Contact closed per pin
  output var  logic [2:0] wake_pin  // Level seen by the block
);
  // Pull-up holds the pin high unless the contact is closed
  always_comb wake_pin = ~closed;
endmodule
`default_nettype wire

/* File: bench/test_cyclic_sense_wake_timers.sv */
// Self-checking bench for the cyclic sense and wake timers
`timescale 1ns/1ps
`default_nettype none
module test_cyclic_sense_wake_timers;
  import ccw_pkg::*;
  localparam int TICK = 10;        // Clocks per tick in simulation
  logic        clock;              // System clock
  logic        rst;                // Reset, high
  ccw_av_req_t req;                // Bus request
  ccw_av_rsp_t rsp;                // Bus answer
  ccw_mode_t   mode;               // Chip mode
  logic [2:0]  closed;             // Contact state
  logic [2:0]  pin;                // Wake pins
  logic [3:0]  fault;              // Switch faults
  logic [3:0]  hs;                 // Switch drive
  logic        int_n;              // Interrupt, low
  logic        sup_en;             // Supply enable
  logic        rreq;               // Restart request
  logic        fail;               // Config failure
  logic [31:0] rd;                 // Last read data
  int          bad_count;          // Mismatches
  int          samples_checked;    // Comparisons
  int          seed;               // Random seed
  int          c;                  // On-cycle count
  ccw_timers #(.TICK_CYC(TICK)) i_ccw_timers (.clock(clock), .rst(rst), .av_req(req),
    .av_rsp(rsp), .mode_i(mode), .wake_pin(pin), .hs_fault(fault), .high_side_switch(hs),
    .int_n(int_n), .supply_en(sup_en), .restart_req(rreq), .spi_fail(fail));
  ccw_wake_net i_ccw_wake_net (.closed(closed), .wake_pin(pin));
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    summarize();
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d);
    int i;
    @(posedge clock);
    req <= '{address: a, read: !wr, write: wr, writedata: {24'h0, d}, byteenable: 4'hF};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (rsp.waitrequest === 1'b0)
        break;
    end
    if (i == 20)
      hang();
    rd = rsp.readdata;
    req <= '0;
  endtask
  // Bounded wait for the interrupt to go low
  task automatic wait_low(input int lim);
    int i;
    for (i = 0; i < lim && int_n !== 1'b0; i++)
      @(posedge clock);
    if (i == lim)
      hang();
  endtask
  // Clocks that switch 0 is on within a window
  task automatic count_on(input int k);
    c = 0;
    repeat (k)
    begin
      @(posedge clock);
      c += (hs[0] === 1'b1);
    end
  endtask
  function automatic logic [7:0] tcfg(input logic [2:0] on, input logic [2:0] per);
    return {1'b0, on, 1'b0, per};
  endfunction
  function automatic int on_clk(input logic [14:0] t);
    return int'(t) * TICK;
  endfunction
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    seed = 57;
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    req = '0;
    mode = CCW_NORMAL;
    closed = 3'h0;
    fault = 4'h0;
    tick(3);
    rst <= 1'b0;
    tick(2);
    check("int_n", int_n, 1'b1);
    check("hs", hs, 4'h0);
    bus(REG_TMR1, 1'b0, 8'h00);
    check("tmr1 reset", rd, REG_RST);
    bus(5'h03, 1'b1, 8'($random(seed)));
    bus(5'h03, 1'b0, 8'h00);
    check("unmapped", rd, 32'h0);
    bus(REG_TMR1, 1'b1, tcfg(ON_OFF_HIGH, 3'h1));
    bus(REG_HS, 1'b1, {4'h0, HS_SEL_ON, HS_SEL_T1});
    tick(2);
    check("idle level", hs, 4'h3);
    bus(REG_WKC, 1'b1, 8'h01);
    bus(REG_TMR1, 1'b1, tcfg(ON_1MS, 3'h1));
    tick(5);
    count_on(2000);
    check("on clocks", c, on_clk(ON_T_1MS));
    tick($unsigned($random(seed)) % 20);
    // Sense wake while in Stop mode
    mode <= CCW_STOP;
    closed[0] <= 1'b1;
    wait_low(2500);
    mode <= CCW_NORMAL;
    bus(REG_WKF1, 1'b0, 8'h00);
    check("pin flags", rd, 32'h1);
    bus(REG_LVL, 1'b0, 8'h00);
    check("level", rd[0], 1'b0);
    bus(REG_WKF1, 1'b1, 8'h01);
    tick(3);
    check("int clear", int_n, 1'b1);
    closed[0] <= 1'b0;
    wait_low(4500);
    mode <= CCW_SLEEP;
    tick(4);
    check("restart", {rreq, sup_en}, 2'h3);
    mode <= CCW_NORMAL;
    bus(REG_WKF1, 1'b1, 8'h07);
    // Fault cuts the switch, timer runs on
    tick($unsigned($random(seed)) % 50);
    fault[0] <= 1'b1;
    tick(1);
    fault[0] <= 1'b0;
    count_on(2000);
    check("fault off", c, 0);
    bus(REG_HS, 1'b1, {4'h0, HS_SEL_ON, HS_SEL_T1});
    count_on(2000);
    check("timer runs", c, on_clk(ON_T_1MS));
    bus(REG_TMR2, 1'b1, tcfg(ON_20MS, 3'h0));
    tick(2);
    check("spi_fail", fail, 1'b1);
    bus(REG_STAT, 1'b1, 8'h01);
    bus(REG_TMR2, 1'b1, tcfg(ON_OFF_LOW, 3'h0));
    bus(REG_WKC, 1'b1, 8'h81);
    bus(REG_TMR2, 1'b1, tcfg(ON_100US, 3'h0));
    tick(50);
    bus(REG_WKF2, 1'b0, 8'h00);
    check("no first", rd, 32'h0);
    tick(1000);
    bus(REG_WKF2, 1'b0, 8'h00);
    check("cyc wake", rd, 32'h2);
    check("cyc int", int_n, 1'b0);
    mode <= CCW_FAILSAFE;
    tick(3);
    check("failsafe", hs, 4'h0);
    summarize();
  end
endmodule
`default_nettype wire

/* File: src/ccw_pkg.sv */
// Constants, field layouts and carrier types for the cyclic sense and wake timers
`default_nettype none
package ccw_pkg;
  // Block dimensions
  localparam int NUM_TMR = 2;                  // Internal wake timers
  localparam int NUM_WK  = 3;                  // Wake pins
  localparam int NUM_HS  = 4;                  // High-side switches
  // Timebase
  localparam int CLK_PERIOD_NS = 10;           // 100 MHz system clock
  localparam int TICK_NS       = 100000;       // 0.1 ms timer tick
  localparam int TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;
  localparam int FILT_NS       = 16000;        // Wake filter time, 16 us
  localparam int FILT_CYC      = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W        = 11;           // Filter counter width
  localparam int TCNT_W        = 15;           // Timer tick counter width
  // Period lengths in ticks
  localparam logic [14:0] PER_10MS  = 15'h0064;
  localparam logic [14:0] PER_20MS  = 15'h00C8;
  localparam logic [14:0] PER_50MS  = 15'h01F4;
  localparam logic [14:0] PER_100MS = 15'h03E8;
  localparam logic [14:0] PER_200MS = 15'h07D0;
  localparam logic [14:0] PER_1S    = 15'h2710;
  localparam logic [14:0] PER_2S    = 15'h4E20;
  // On-time lengths in ticks
  localparam logic [14:0] ON_T_100US = 15'h0001;
  localparam logic [14:0] ON_T_300US = 15'h0003;
  localparam logic [14:0] ON_T_1MS   = 15'h000A;
  localparam logic [14:0] ON_T_10MS  = 15'h0064;
  localparam logic [14:0] ON_T_20MS  = 15'h00C8;
  localparam logic [14:0] ON_T_NONE  = 15'h0000;
  // Timer config field codes and positions
  localparam logic [2:0] ON_OFF_LOW  = 3'h0;   // Stopped, output low
  localparam logic [2:0] ON_OFF_HIGH = 3'h1;   // Stopped, output high
  localparam logic [2:0] ON_100US    = 3'h2;
  localparam logic [2:0] ON_300US    = 3'h3;
  localparam logic [2:0] ON_1MS      = 3'h4;
  localparam logic [2:0] ON_10MS     = 3'h5;
  localparam logic [2:0] ON_20MS     = 3'h6;
  localparam int TMR_PER_LSB = 0;              // Period code [2:0]
  localparam int TMR_ON_LSB  = 4;              // On-time code [6:4]
  // Switch mapping codes, two bits per switch
  localparam logic [1:0] HS_SEL_OFF = 2'h0;
  localparam logic [1:0] HS_SEL_T1  = 2'h1;
  localparam logic [1:0] HS_SEL_T2  = 2'h2;
  localparam logic [1:0] HS_SEL_ON  = 2'h3;
  // Wake control fields
  localparam int WKC_CS_LSB   = 0;             // Cyclic sense enable per pin
  localparam int WKC_TSEL_LSB = 3;             // Timer select per pin
  localparam int WKC_CW_LSB   = 6;             // Cyclic wake enable per timer
  localparam int STAT_SPI_FAIL = 0;            // Status bit: config failure
  // Register byte addresses
  localparam logic [4:0] REG_TMR1 = 5'h00;
  localparam logic [4:0] REG_TMR2 = 5'h04;
  localparam logic [4:0] REG_HS   = 5'h08;
  localparam logic [4:0] REG_WKC  = 5'h0C;
  localparam logic [4:0] REG_WKF1 = 5'h10;
  localparam logic [4:0] REG_WKF2 = 5'h14;
  localparam logic [4:0] REG_LVL  = 5'h18;
  localparam logic [4:0] REG_STAT = 5'h1C;
  localparam logic [7:0] REG_RST  = 8'h00;     // Reset value of all registers
  // Operating mode of the surrounding chip, one-hot
  typedef enum logic [3:0] {
    CCW_NORMAL   = 4'h1,
    CCW_STOP     = 4'h2,
    CCW_SLEEP    = 4'h4,
    CCW_FAILSAFE = 4'h8
  } ccw_mode_t;
  // Avalon-MM request and answer
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ccw_av_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } ccw_av_rsp_t;
endpackage
`default_nettype wire

/* File: src/ccw_timers.sv */
// Cyclic sense and cyclic wake timers with Avalon-MM register slave
// Operation
// [R1] Mapped switches pulse per timer period, on-time
// [R2] Pin change wakes: interrupt low, or supply on
// [R3] Off-low/off-high set idle switch level
// [R4] Writing active on-time starts timer immediately
// [R5] Host configures level, mapping, pins, then timer
// [R6] On-time above period sets failure flag
// [R7] First sample is reference; difference wakes
// [R8] 16us stable filter after on-time end
// [R9] Sense wake sets that pin's wake flag
// [R10] Level status takes sampled levels only; code: cyclic sense pins in Normal/Stop only, live pin level otherwise
// [R11] Fail-safe: switches off, pins static sensing
// [R12] Switch faults disable that switch
// [R13] Timer keeps running after switch fault
// [R14] Host enables cyclic sense before low power
// [R15] Stop wake interrupts; Sleep wake restarts
// [R16] Uncleared flags at Sleep force restart
// [R17] Enabled cyclic wake timer interrupts periodically
// [R18] Host disables, enables source, then programs timer
// [R19] No interrupt at very first on-time start
// [R20] Any timer maps to any switch
// [R21] Seven selectable periods, 10ms to 2s
// [R22] Five on-times or off high/low
// [R23] Period and on-time as encoded fields
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccw_timers #(
  parameter int TICK_CYC = ccw_pkg::TICK_CYC_DEF    // Clocks per 0.1 ms tick
) (
  input  wire logic                clock,       // System clock
  input  wire logic                rst,         // Async reset, high
  input  wire ccw_pkg::ccw_av_req_t av_req,     // Avalon request
  output var  ccw_pkg::ccw_av_rsp_t av_rsp,     // Avalon answer
  input  wire ccw_pkg::ccw_mode_t  mode_i,      // Chip operating mode
  input  wire logic [2:0]          wake_pin,    // Wake pin levels
  input  wire logic [3:0]          hs_fault,    // Switch fault events
  output var  logic [3:0]          high_side_switch, // Switch drive
  output var  logic                int_n,       // Interrupt, low active
  output var  logic                supply_en,   // Main supply rail enable
  output var  logic                restart_req, // Restart request
  output var  logic                spi_fail     // Config failure flag
);
  import ccw_pkg::*;

  // Period code to tick count
  function automatic logic [14:0] period_ticks(input logic [2:0] code);
    case (code)
      3'h0:    period_ticks = PER_10MS;
      3'h1:    period_ticks = PER_20MS;
      3'h2:    period_ticks = PER_50MS;
      3'h3:    period_ticks = PER_100MS;
      3'h4:    period_ticks = PER_200MS;
      3'h5:    period_ticks = PER_1S;
      default: period_ticks = PER_2S;
    endcase
  endfunction

  // On-time code to tick count, zero when stopped
  function automatic logic [14:0] on_ticks(input logic [2:0] code);
    case (code)
      ON_100US: on_ticks = ON_T_100US;
      ON_300US: on_ticks = ON_T_300US;
      ON_1MS:   on_ticks = ON_T_1MS;
      ON_10MS:  on_ticks = ON_T_10MS;
      ON_20MS:  on_ticks = ON_T_20MS;
      default:  on_ticks = ON_T_NONE;
    endcase
  endfunction

  localparam logic [15:0]       TICK_LAST = 16'(TICK_CYC - 1);
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);

  logic [7:0]        tmr_cfg_q [NUM_TMR];  // Timer configs
  logic [7:0]        hs_cfg_q;             // Switch mapping
  logic [7:0]        wkc_q;                // Wake source control
  logic [NUM_WK-1:0] wkf1_q;               // Pin wake flags
  logic [NUM_TMR-1:0] wkf2_q;              // Timer wake flags
  logic [NUM_WK-1:0] lvl_q;                // Pin level status
  logic              spi_fail_q;           // Config failure flag
  logic [3:0]        hs_on_q;              // Switch drive
  logic [3:0]        fault_q;              // Latched switch faults
  logic              int_n_q;              // Interrupt output
  logic              supply_q;             // Supply enable
  logic              rst_req_q;            // Restart pending
  logic [15:0]       pres_q;               // Tick prescaler
  logic              tick;                 // One tick pulse
  ccw_av_rsp_t       rsp_q;                // Bus answer
  logic [31:0]       rdata;                // Read mux
  logic              wr_go;                // Write commits this edge
  logic [TCNT_W-1:0] tcnt_q [NUM_TMR];     // Tick counter per timer
  logic [NUM_TMR-1:0] tmr_run;             // Timer running
  logic [NUM_TMR-1:0] tmr_lvl;             // Timer output level
  logic [NUM_TMR-1:0] on_end;              // End of on-time pulse
  logic [NUM_TMR-1:0] cw_evt;              // Later on-time start pulse
  logic [NUM_TMR-1:0] tmr_wr;              // Timer config written
  logic [NUM_WK-1:0]  pin_wake;            // Filtered pin wake
  logic [NUM_WK-1:0]  samp_done;           // Filter finished stable
  logic [NUM_WK-1:0]  cs_en;               // Cyclic sense active per pin
  logic [NUM_WK-1:0]  busy_q;              // Filter running
  logic [NUM_WK-1:0]  flev_q;              // Level at filter start
  logic [NUM_WK-1:0]  ref_q;               // Reference level
  logic [NUM_WK-1:0]  refv_q;              // Reference valid
  logic [FILT_W-1:0]  fcnt_q [NUM_WK];     // Filter counter
  logic               ns_mode;             // Normal or Stop
  logic               fs_mode;             // Fail-safe
  logic               any_flag;            // Any wake flag set

  assign ns_mode  = (mode_i == CCW_NORMAL) || (mode_i == CCW_STOP);
  assign fs_mode  = (mode_i == CCW_FAILSAFE);
  assign any_flag = (|wkf1_q) || (|wkf2_q);
  assign wr_go    = av_req.write && !rsp_q.waitrequest && av_req.byteenable[0];
  assign tick     = (pres_q == TICK_LAST);

  // Outputs straight from flip-flops
  assign av_rsp           = rsp_q;
  assign high_side_switch = hs_on_q;
  assign int_n            = int_n_q;
  assign supply_en        = supply_q;
  assign restart_req      = rst_req_q;
  assign spi_fail         = spi_fail_q;

  // Read data decode, unmapped reads as zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (av_req.address == REG_TMR1)      rdata[7:0] = tmr_cfg_q[0];
    else if (av_req.address == REG_TMR2) rdata[7:0] = tmr_cfg_q[1];
    else if (av_req.address == REG_HS)   rdata[7:0] = hs_cfg_q;
    else if (av_req.address == REG_WKC)  rdata[7:0] = wkc_q;
    else if (av_req.address == REG_WKF1) rdata[NUM_WK-1:0] = wkf1_q;
    else if (av_req.address == REG_WKF2) rdata[NUM_TMR-1:0] = wkf2_q;
    else if (av_req.address == REG_LVL)  rdata[NUM_WK-1:0] = lvl_q;
    else if (av_req.address == REG_STAT) rdata[STAT_SPI_FAIL] = spi_fail_q;
  end

  // Bus answer: one wait state, then waitrequest low for one cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rsp_q.waitrequest <= 1'b1;
      rsp_q.readdata    <= 32'h0000_0000;
    end
    else if ((av_req.read || av_req.write) && rsp_q.waitrequest)
    begin
      rsp_q.waitrequest <= 1'b0;
      rsp_q.readdata    <= rdata;
    end
    else
      rsp_q.waitrequest <= 1'b1;
  end

  // Configuration registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tmr_cfg_q[0] <= REG_RST;
      tmr_cfg_q[1] <= REG_RST;
      hs_cfg_q     <= REG_RST;
      wkc_q        <= REG_RST;
    end
    else if (wr_go)
    begin
      if (av_req.address == REG_TMR1)      tmr_cfg_q[0] <= av_req.writedata[7:0];
      else if (av_req.address == REG_TMR2) tmr_cfg_q[1] <= av_req.writedata[7:0];
      else if (av_req.address == REG_HS)   hs_cfg_q <= av_req.writedata[7:0];
      else if (av_req.address == REG_WKC)  wkc_q <= av_req.writedata[7:0];
    end
  end

  // Failure flag on bad timer pairing, set wins over clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      spi_fail_q <= 1'b0;
    // [R6] on-time above period
    else if (wr_go && (av_req.address == REG_TMR1 || av_req.address == REG_TMR2)
             && on_ticks(av_req.writedata[TMR_ON_LSB +: 3])
                > period_ticks(av_req.writedata[TMR_PER_LSB +: 3]))
      spi_fail_q <= 1'b1;
    else if (wr_go && av_req.address == REG_STAT && av_req.writedata[STAT_SPI_FAIL])
      spi_fail_q <= 1'b0;
  end

  // Shared 0.1 ms tick prescaler
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pres_q <= 16'h0000;
    else if (tick)
      pres_q <= 16'h0000;
    else
      pres_q <= pres_q + 16'h0001;
  end

  assign tmr_wr[0] = wr_go && (av_req.address == REG_TMR1);
  assign tmr_wr[1] = wr_go && (av_req.address == REG_TMR2);

  // Timers
  for (genvar t = 0; t < NUM_TMR; t++)
  begin : g_tmr
    logic [14:0] per_t;  // Period in ticks
    logic [14:0] on_t;   // On-time in ticks
    logic [2:0]  on_c;   // On-time code
    // [R21] [R22] [R23] encoded field decode
    assign on_c  = tmr_cfg_q[t][TMR_ON_LSB +: 3];
    assign per_t = period_ticks(tmr_cfg_q[t][TMR_PER_LSB +: 3]);
    assign on_t  = on_ticks(on_c);
    // [R4] running once on-time active
    assign tmr_run[t] = (on_t != ON_T_NONE) && !fs_mode;
    assign on_end[t]  = tmr_run[t] && tick && (tcnt_q[t] == on_t - 15'h0001);
    // [R19] first start is the counter reset, only wraps count
    assign cw_evt[t]  = tmr_run[t] && tick && (tcnt_q[t] == per_t - 15'h0001);
    // [R3] stopped timer holds chosen level
    assign tmr_lvl[t] = tmr_run[t] ? (tcnt_q[t] < on_t) : (on_c == ON_OFF_HIGH);

    // Tick counter, restarted by every write to its own timer config
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
        tcnt_q[t] <= ON_T_NONE;
      else if (!tmr_run[t] || tmr_wr[t])
        tcnt_q[t] <= ON_T_NONE;
      // [R13] faults never stop the count
      else if (cw_evt[t])
        tcnt_q[t] <= ON_T_NONE;
      else if (tick)
        tcnt_q[t] <= tcnt_q[t] + 15'h0001;
    end
  end

  // Switch fault latches, cleared by rewriting the mapping
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      fault_q <= 4'h0;
    else
    begin
      for (int i = 0; i < NUM_HS; i++)
      begin
        // [R12] fault disables switch
        if (hs_fault[i] && !fs_mode)
          fault_q[i] <= 1'b1;
        else if (wr_go && av_req.address == REG_HS)
          fault_q[i] <= 1'b0;
      end
    end
  end

  // Switch drive from mapping
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      hs_on_q <= 4'h0;
    else
    begin
      for (int i = 0; i < NUM_HS; i++)
      begin
        // [R11] fail-safe forces off
        if (fs_mode || fault_q[i])
          hs_on_q[i] <= 1'b0;
        // [R1] [R20] any timer to any switch
        else if (hs_cfg_q[2*i +: 2] == HS_SEL_T1)
          hs_on_q[i] <= tmr_lvl[0];
        else if (hs_cfg_q[2*i +: 2] == HS_SEL_T2)
          hs_on_q[i] <= tmr_lvl[1];
        else
          hs_on_q[i] <= (hs_cfg_q[2*i +: 2] == HS_SEL_ON);
      end
    end
  end

  // Wake pin sampling with stability filter
  for (genvar p = 0; p < NUM_WK; p++)
  begin : g_pin
    logic tsel;  // Timer feeding this pin
    logic trig;  // Start a filter window
    assign tsel  = wkc_q[WKC_TSEL_LSB + p];
    assign cs_en[p] = wkc_q[WKC_CS_LSB + p] && !fs_mode;
    // [R11] fail-safe samples statically on any change
    assign trig  = !busy_q[p] && (cs_en[p] ? on_end[tsel]
                 : fs_mode && (!refv_q[p] || wake_pin[p] != ref_q[p]));
    // [R8] full window stable
    assign samp_done[p] = busy_q[p] && (fcnt_q[p] == FILT_LAST)
                        && (wake_pin[p] == flev_q[p]);
    // [R2] [R7] differs from reference
    assign pin_wake[p] = samp_done[p] && refv_q[p] && (flev_q[p] != ref_q[p]);

    // Filter window and reference
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        busy_q[p] <= 1'b0;
        flev_q[p] <= 1'b0;
        fcnt_q[p] <= '0;
        ref_q[p]  <= 1'b0;
        refv_q[p] <= 1'b0;
      end
      else if (!cs_en[p] && !fs_mode)
      begin
        busy_q[p] <= 1'b0;
        refv_q[p] <= 1'b0;
      end
      else if (trig)
      begin
        busy_q[p] <= 1'b1;
        flev_q[p] <= wake_pin[p];
        fcnt_q[p] <= '0;
      end
      else if (busy_q[p] && wake_pin[p] != flev_q[p])
        busy_q[p] <= 1'b0;
      else if (samp_done[p])
      begin
        busy_q[p] <= 1'b0;
        ref_q[p]  <= flev_q[p];
        refv_q[p] <= 1'b1;
      end
      else if (busy_q[p])
        fcnt_q[p] <= fcnt_q[p] + FILT_W'(1);
    end

    // Level status
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
        lvl_q[p] <= 1'b0;
      // [R10] sampled levels for cyclic sense pins in Normal/Stop, live pin level otherwise
      else if (cs_en[p] && ns_mode)
        lvl_q[p] <= samp_done[p] ? flev_q[p] : lvl_q[p];
      else
        lvl_q[p] <= wake_pin[p];
    end
  end

  // Wake flags, write one to clear, set wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wkf1_q <= '0;
      wkf2_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_WK; p++)
      begin
        // [R9] flag per pin
        if (pin_wake[p])
          wkf1_q[p] <= 1'b1;
        else if (wr_go && av_req.address == REG_WKF1 && av_req.writedata[p])
          wkf1_q[p] <= 1'b0;
      end
      for (int t = 0; t < NUM_TMR; t++)
      begin
        // [R17] periodic timer wake
        if (cw_evt[t] && wkc_q[WKC_CW_LSB + t] && ns_mode)
          wkf2_q[t] <= 1'b1;
        else if (wr_go && av_req.address == REG_WKF2 && av_req.writedata[t])
          wkf2_q[t] <= 1'b0;
      end
    end
  end

  // Interrupt, restart and supply
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      int_n_q   <= 1'b1;
      rst_req_q <= 1'b0;
      supply_q  <= 1'b0;
    end
    else
    begin
      // [R2] [R15] interrupt in Normal or Stop
      int_n_q <= !(ns_mode && any_flag);
      // [R15] [R16] pending flag in Sleep restarts
      if (!ns_mode && any_flag)
        rst_req_q <= 1'b1;
      else if (ns_mode)
        rst_req_q <= 1'b0;
      supply_q <= ns_mode || any_flag || rst_req_q;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_hs_map;
    (hs_cfg_q[1:0] == HS_SEL_T1 && !fault_q[0] && !fs_mode) |=> hs_on_q[0] == $past(tmr_lvl[0]);
  endproperty
  a_hs_map: assert property (p_hs_map) else $error("switch not following timer"); // [R1]
  property p_int;
    (ns_mode && pin_wake[0]) ##1 ns_mode |=> !int_n_q;
  endproperty
  a_int: assert property (p_int) else $error("pin wake without interrupt"); // [R2]
  property p_start;
    (tmr_wr[0] && on_ticks(av_req.writedata[TMR_ON_LSB +: 3]) != ON_T_NONE && !fs_mode)
      |=> tmr_run[0] && tcnt_q[0] == ON_T_NONE;
  endproperty
  a_start: assert property (p_start) else $error("timer not started by write"); // [R4]
  property p_fail;
    (tmr_wr[1] && on_ticks(av_req.writedata[TMR_ON_LSB +: 3])
       > period_ticks(av_req.writedata[TMR_PER_LSB +: 3])) |=> spi_fail_q;
  endproperty
  a_fail: assert property (p_fail) else $error("failure flag missing"); // [R6]
  property p_filt;
    pin_wake[0] |-> fcnt_q[0] == FILT_LAST && $stable(wake_pin[0]) && refv_q[0];
  endproperty
  a_filt: assert property (p_filt) else $error("wake before filter end"); // [R8]
  property p_flag;
    pin_wake[0] |=> wkf1_q[0];
  endproperty
  a_flag: assert property (p_flag) else $error("wake flag not set"); // [R9]
  property p_fs;
    fs_mode |=> hs_on_q == 4'h0;
  endproperty
  a_fs: assert property (p_fs) else $error("switch on in fail-safe"); // [R11]
  property p_fault;
    (hs_fault[0] && !fs_mode) |-> ##2 !hs_on_q[0];
  endproperty
  a_fault: assert property (p_fault) else $error("faulted switch still on"); // [R12]
  property p_keep;
    (tmr_run[0] && tick && !cw_evt[0] && !tmr_wr[0]) ##1 tmr_run[0]
      |-> tcnt_q[0] == $past(tcnt_q[0]) + 15'h0001;
  endproperty
  a_keep: assert property (p_keep) else $error("timer count stalled"); // [R13]
  property p_sleep;
    (mode_i == CCW_SLEEP && any_flag) |=> rst_req_q && supply_q;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no restart on pending wake"); // [R16]
  property p_cw;
    (cw_evt[1] && wkc_q[WKC_CW_LSB + 1] && ns_mode) |=> wkf2_q[1] ##1 (!int_n_q || !ns_mode);
  endproperty
  a_cw: assert property (p_cw) else $error("cyclic wake not signalled"); // [R17]

  c_wake: cover property (pin_wake[0] && ns_mode);
  c_restart: cover property ($rose(rst_req_q));
  c_cw: cover property (cw_evt[0] && wkc_q[WKC_CW_LSB]);
endmodule
`default_nettype wire
